/* fep_core.sv */
// Fetch and execute sequencer of an 8-bit core with byte-addressed program memory.
// Assumes program and data memory answer combinationally on sys_clk, and clk_en from the same domain.
`timescale 1ns/100ps
`include "fep_defs.svh"
module fep_core (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic [15:0] pm_rdata,
  input  wire logic [7:0]  dm_rdata,
  output wire logic        phase_one,
  output wire logic        phase_two,
  output wire logic        phase_three,
  output wire logic        phase_four,
  output wire logic [20:0] program_counter,
  output wire logic [20:0] pm_addr,
  output wire logic        pm_wr_strobe,
  output wire logic [7:0]  pm_wr_data,
  output wire logic [11:0] dm_addr,
  output wire logic        dm_rd_strobe,
  output wire logic        dm_wr_strobe,
  output wire logic [7:0]  dm_wdata,
  output wire logic [7:0]  working_register,
  output wire logic [15:0] instruction_holding_register,
  output wire logic        slot_live,
  output wire logic [20:0] table_pointer,
  output wire logic [7:0]  table_latch,
  output wire logic [11:0] load_pointer
);
  import fep_pkg::*;

  fep_phase_t  phase_reg, phase_next;
  fep_op_t     op_reg, prev_op_reg, op_new;
  logic [3:0]  phase_oh_reg;
  logic [20:0] pc_reg, pm_addr_reg, ret_addr_reg, tptr_reg, next_addr, target;
  logic [15:0] fetched_reg, ir_reg, prev_ir_reg;
  logic [11:0] dm_addr_reg, lptr_reg, new_addr;
  logic [7:0]  operand_reg, dm_wdata_reg, w_reg, tlatch_reg, pm_wr_data_reg, sum, sfr_rdata, wdata;
  logic        flush_reg, live_reg, cont_reg, dm_rd_reg, reading_reg, dm_wr_reg, wr_pending_reg, pm_wr_reg;
  logic        end_one, end_two, end_three, end_four, new_reads, cont_new, second_ok, writes_file;
  logic        table_op, take_branch, do_skip;

  // Access-bank mapping: below 0x60 is the low bank, 0x60 and up the special register bank; bit 8 set always picks the low bank
  function automatic logic [11:0] fep_file_addr(input logic [15:0] word);
    logic [7:0] f;
    f = word[7:0];
    if (word[8])
      fep_file_addr = {`FEP_LOW_BANK, f};
    else if (f >= `FEP_ACCESS_SPLIT)
      fep_file_addr = {`FEP_SFR_BANK, f};
    else
      fep_file_addr = {`FEP_LOW_BANK, f};
  endfunction : fep_file_addr

  // Registers held inside the core rather than on the data bus
  function automatic logic fep_is_sfr(input logic [11:0] a);
    fep_is_sfr = (a == `FEP_PCLOW_ADDR) || (a == `FEP_TPTR_L_ADDR) || (a == `FEP_TPTR_H_ADDR) ||
                 (a == `FEP_TPTR_U_ADDR) || (a == `FEP_TLATCH_ADDR);
  endfunction : fep_is_sfr

  assign phase_one                    = phase_oh_reg[0];
  assign phase_two                    = phase_oh_reg[1];
  assign phase_three                  = phase_oh_reg[2];
  assign phase_four                   = phase_oh_reg[3];
  assign program_counter              = pc_reg;
  assign pm_addr                      = pm_addr_reg;
  assign pm_wr_strobe                 = pm_wr_reg;
  assign pm_wr_data                   = pm_wr_data_reg;
  assign dm_addr                      = dm_addr_reg;
  assign dm_rd_strobe                 = dm_rd_reg;
  assign dm_wr_strobe                 = dm_wr_reg;
  assign dm_wdata                     = dm_wdata_reg;
  assign working_register             = w_reg;
  assign instruction_holding_register = ir_reg;
  assign slot_live                    = live_reg;
  assign table_pointer                = tptr_reg;
  assign table_latch                  = tlatch_reg;
  assign load_pointer                 = lptr_reg;

  assign end_one   = clk_en && (phase_reg == PH_ONE);
  assign end_two   = clk_en && (phase_reg == PH_TWO);
  assign end_three = clk_en && (phase_reg == PH_THREE);
  assign end_four  = clk_en && (phase_reg == PH_FOUR);

  always_comb begin
    case (phase_reg)
      PH_ONE:   phase_next = PH_TWO;
      PH_TWO:   phase_next = PH_THREE;
      PH_THREE: phase_next = PH_FOUR;
      PH_FOUR:  phase_next = PH_ONE;
      default:  phase_next = PH_ONE;
    endcase
  end

  // Each phase lasts one enabled clock; four of them make one instruction cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_reg    <= PH_ONE;
      phase_oh_reg <= 4'h1;
    end else if (clk_en) begin
      phase_reg    <= phase_next;
      phase_oh_reg <= {phase_next == PH_FOUR, phase_next == PH_THREE,
                       phase_next == PH_TWO, phase_next == PH_ONE};
    end
  end

  // Decode of the word about to enter the holding register
  always_comb begin
    op_new = OP_NOP;
    if (fetched_reg[15:12] == `FEP_CONT_PREFIX)
      op_new = OP_CONT;
    else if (fetched_reg[15:8] == `FEP_OP_JUMP)
      op_new = OP_JUMP1;
    else if (fetched_reg[15:8] == `FEP_OP_LOAD_PTR)
      op_new = OP_LPTR1;
    else if (fetched_reg[15:9] == `FEP_OP_CALL)
      op_new = OP_CALL1;
    else if (fetched_reg[15:12] == `FEP_OP_FILE_MOVE)
      op_new = OP_FMOVE1;
    else if (fetched_reg[15:11] == `FEP_OP_BRANCH)
      op_new = OP_BRANCH;
    else if (fetched_reg[15:9] == `FEP_OP_STORE_W)
      op_new = OP_STORE_W;
    else if (fetched_reg[15:9] == `FEP_OP_SKIP_ZERO)
      op_new = OP_SKIP_ZERO;
    else if (fetched_reg[15:10] == `FEP_OP_ADD_FILE)
      op_new = OP_ADD_FILE;
    else if (fetched_reg[15:8] == `FEP_OP_RET_LIT)
      op_new = OP_RET_LIT;
    else if (fetched_reg[15:8] == `FEP_OP_LOAD_LIT)
      op_new = OP_LOAD_LIT;
    else if (fetched_reg == `FEP_OP_TRD)
      op_new = OP_TRD;
    else if (fetched_reg == `FEP_OP_TRD_INC)
      op_new = OP_TRD_INC;
    else if (fetched_reg == `FEP_OP_TWR)
      op_new = OP_TWR;
  end

  assign new_addr  = (op_new == OP_FMOVE1 || op_new == OP_CONT) ? fetched_reg[11:0] : fep_file_addr(fetched_reg);
  assign new_reads = (op_new == OP_ADD_FILE) || (op_new == OP_SKIP_ZERO) || (op_new == OP_FMOVE1);
  // A continuation counts only right after its own live first word
  assign cont_new  = live_reg && ((op_reg == OP_JUMP1) || (op_reg == OP_CALL1) ||
                                  (op_reg == OP_LPTR1) || (op_reg == OP_FMOVE1));
  assign second_ok = (op_reg == OP_CONT) && cont_reg;
  assign writes_file = live_reg && ((op_reg == OP_ADD_FILE && ir_reg[9]) || (op_reg == OP_STORE_W) ||
                                    (second_ok && prev_op_reg == OP_FMOVE1));
  assign table_op  = live_reg && ((op_reg == OP_TRD) || (op_reg == OP_TRD_INC) || (op_reg == OP_TWR));
  assign sum       = w_reg + operand_reg;
  // Address of the word following the executing one
  assign next_addr = pc_reg - `FEP_PC_STEP;

  always_comb begin
    case (dm_addr_reg)
      `FEP_PCLOW_ADDR:  sfr_rdata = next_addr[7:0];
      `FEP_TPTR_L_ADDR: sfr_rdata = tptr_reg[7:0];
      `FEP_TPTR_H_ADDR: sfr_rdata = tptr_reg[15:8];
      `FEP_TPTR_U_ADDR: sfr_rdata = {3'h0, tptr_reg[20:16]};
      `FEP_TLATCH_ADDR: sfr_rdata = tlatch_reg;
      default:          sfr_rdata = `FEP_RESET_BYTE;
    endcase
  end

  always_comb begin
    case (op_reg)
      OP_ADD_FILE: wdata = sum;
      OP_STORE_W:  wdata = w_reg;
      default:     wdata = operand_reg;
    endcase
  end

  // Program-counter changes, resolved at the end of phase four
  always_comb begin
    take_branch = 1'b0;
    do_skip     = 1'b0;
    target      = next_addr;
    if (live_reg) begin
      if (wr_pending_reg && dm_addr_reg == `FEP_PCLOW_ADDR) begin
        take_branch = 1'b1;
        target      = {next_addr[20:8], dm_wdata_reg[7:1], 1'b0};
      end else begin
        case (op_reg)
          OP_BRANCH: begin
            take_branch = 1'b1;
            target      = next_addr + {{9{ir_reg[10]}}, ir_reg[10:0], 1'b0};
          end
          OP_RET_LIT: begin
            take_branch = 1'b1;
            target      = ret_addr_reg;
          end
          OP_SKIP_ZERO: do_skip = (operand_reg == `FEP_RESET_BYTE);
          OP_CONT: begin
            if (cont_reg && (prev_op_reg == OP_JUMP1 || prev_op_reg == OP_CALL1)) begin
              take_branch = 1'b1;
              target      = {ir_reg[11:0], prev_ir_reg[7:0], 1'b0};
            end
          end
          default:      take_branch = 1'b0;
        endcase
      end
    end
  end

  // Fetch side: counter, program address, prefetch latch, flush
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pc_reg       <= `FEP_RESET_PC;
      pm_addr_reg  <= `FEP_RESET_PC;
      fetched_reg  <= `FEP_RESET_WORD;
      flush_reg    <= 1'b1;
      ret_addr_reg <= `FEP_RESET_PC;
    end else begin
      if (end_one) begin
        pm_addr_reg <= pc_reg;
        pc_reg      <= pc_reg + `FEP_PC_STEP;
        flush_reg   <= 1'b0;
      end
      if (end_two && table_op)
        pm_addr_reg <= tptr_reg;
      if (end_three)
        pm_addr_reg <= next_addr;
      if (end_four) begin
        fetched_reg <= pm_rdata;
        if (take_branch || do_skip)
          flush_reg <= 1'b1;
        if (take_branch)
          pc_reg <= target;
        if (second_ok && prev_op_reg == OP_CALL1)
          ret_addr_reg <= next_addr;
      end
    end
  end

  // Holding register and pipeline flags
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ir_reg      <= `FEP_RESET_WORD;
      prev_ir_reg <= `FEP_RESET_WORD;
      op_reg      <= OP_NOP;
      prev_op_reg <= OP_NOP;
      live_reg    <= 1'b0;
      cont_reg    <= 1'b0;
    end else if (end_one) begin
      ir_reg      <= fetched_reg;
      prev_ir_reg <= ir_reg;
      op_reg      <= op_new;
      prev_op_reg <= op_reg;
      live_reg    <= ~flush_reg;
      cont_reg    <= cont_new;
    end
  end

  // Data memory bus: read in phase two, write in phase four
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dm_addr_reg    <= 12'h000;
      dm_rd_reg      <= 1'b0;
      reading_reg    <= 1'b0;
      operand_reg    <= `FEP_RESET_BYTE;
      dm_wr_reg      <= 1'b0;
      wr_pending_reg <= 1'b0;
      dm_wdata_reg   <= `FEP_RESET_BYTE;
    end else begin
      if (end_one) begin
        dm_addr_reg <= new_addr;
        reading_reg <= ~flush_reg && new_reads;
        dm_rd_reg   <= ~flush_reg && new_reads && !fep_is_sfr(new_addr);
      end
      if (end_two) begin
        dm_rd_reg <= 1'b0;
        if (reading_reg)
          operand_reg <= fep_is_sfr(dm_addr_reg) ? sfr_rdata : dm_rdata;
      end
      if (end_three) begin
        reading_reg    <= 1'b0;
        wr_pending_reg <= writes_file;
        dm_wr_reg      <= writes_file && !fep_is_sfr(dm_addr_reg);
        dm_wdata_reg   <= wdata;
      end
      if (end_four) begin
        dm_wr_reg      <= 1'b0;
        wr_pending_reg <= 1'b0;
      end
    end
  end

  // Working register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      w_reg <= `FEP_RESET_BYTE;
    end else if (end_four && live_reg) begin
      if (op_reg == OP_LOAD_LIT || op_reg == OP_RET_LIT)
        w_reg <= ir_reg[7:0];
      else if (op_reg == OP_ADD_FILE && !ir_reg[9])
        w_reg <= sum;
    end
  end
  // Pointer loaded by the two-word load instruction
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      lptr_reg <= 12'h000;
    else if (end_four && second_ok && prev_op_reg == OP_LPTR1)
      lptr_reg <= {prev_ir_reg[3:0], ir_reg[7:0]};
  end
  // Table pointer and latch: one byte per read or write
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tptr_reg       <= `FEP_RESET_PC;
      tlatch_reg     <= `FEP_RESET_BYTE;
      pm_wr_reg      <= 1'b0;
      pm_wr_data_reg <= `FEP_RESET_BYTE;
    end else begin
      if (end_two && table_op && op_reg == OP_TWR) begin
        pm_wr_reg      <= 1'b1;
        pm_wr_data_reg <= tlatch_reg;
      end
      if (end_three) begin
        pm_wr_reg <= 1'b0;
        if (table_op && (op_reg == OP_TRD || op_reg == OP_TRD_INC))
          tlatch_reg <= tptr_reg[0] ? pm_rdata[15:8] : pm_rdata[7:0];
      end
      if (end_four) begin
        if (live_reg && op_reg == OP_TRD_INC)
          tptr_reg <= tptr_reg + `FEP_TPTR_STEP;
        if (wr_pending_reg) begin
          case (dm_addr_reg)
            `FEP_TPTR_L_ADDR: tptr_reg[7:0]   <= dm_wdata_reg;
            `FEP_TPTR_H_ADDR: tptr_reg[15:8]  <= dm_wdata_reg;
            `FEP_TPTR_U_ADDR: tptr_reg[20:16] <= dm_wdata_reg[4:0];
            `FEP_TLATCH_ADDR: tlatch_reg      <= dm_wdata_reg;
            default:          tlatch_reg      <= tlatch_reg;
          endcase
        end
      end
    end
  end

endmodule : fep_core

/* fep_defs.svh */
// Constants of the fetch and execute sequencer: widths, reset values, addresses, opcode fields.
// Assumes inclusion by bare name from the core only.
`ifndef FEP_DEFS_SVH
`define FEP_DEFS_SVH

`define FEP_RESET_PC      21'h000000
`define FEP_PC_STEP       21'h000002
`define FEP_TPTR_STEP     21'h000001
`define FEP_RESET_WORD    16'h0000
`define FEP_RESET_BYTE    8'h00
`define FEP_CONT_PREFIX   4'hf
`define FEP_ACCESS_SPLIT  8'h60
`define FEP_SFR_BANK      4'hf
`define FEP_LOW_BANK      4'h0
`define FEP_PCLOW_ADDR    12'hff9
`define FEP_TPTR_L_ADDR   12'hff6
`define FEP_TPTR_H_ADDR   12'hff7
`define FEP_TPTR_U_ADDR   12'hff8
`define FEP_TLATCH_ADDR   12'hff5
`define FEP_OP_TRD        16'h0008
`define FEP_OP_TRD_INC    16'h0009
`define FEP_OP_TWR        16'h000c
`define FEP_OP_RET_LIT    8'h0c
`define FEP_OP_LOAD_LIT   8'h0e
`define FEP_OP_ADD_FILE   6'h09
`define FEP_OP_STORE_W    7'h37
`define FEP_OP_SKIP_ZERO  7'h33
`define FEP_OP_BRANCH     5'h1a
`define FEP_OP_CALL       7'h76
`define FEP_OP_LOAD_PTR   8'hee
`define FEP_OP_JUMP       8'hef
`define FEP_OP_FILE_MOVE  4'hc

`endif

/* fep_pkg.sv */
// Types of the fetch and execute sequencer: phase states and decoded operations.
// Assumes fep_defs.svh sits in the same folder.
package fep_pkg;

  typedef enum logic [1:0] {
    PH_ONE,
    PH_TWO,
    PH_THREE,
    PH_FOUR
  } fep_phase_t;

  typedef enum logic [3:0] {
    OP_NOP,
    OP_LOAD_LIT,
    OP_RET_LIT,
    OP_ADD_FILE,
    OP_STORE_W,
    OP_SKIP_ZERO,
    OP_BRANCH,
    OP_JUMP1,
    OP_CALL1,
    OP_LPTR1,
    OP_FMOVE1,
    OP_CONT,
    OP_TRD,
    OP_TRD_INC,
    OP_TWR
  } fep_op_t;

endpackage : fep_pkg

/* fep_core_monitor.sv */
// Checker of the fetch and execute sequencer, bound to fep_core ports.
// Assumes one clock domain, sys_clk rising edge, rst asynchronous active high.
`timescale 1ns/100ps
module fep_core_monitor (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        clk_en,
  input wire logic        phase_one,
  input wire logic        phase_two,
  input wire logic        phase_three,
  input wire logic        phase_four,
  input wire logic [20:0] program_counter,
  input wire logic [20:0] pm_addr,
  input wire logic        pm_wr_strobe,
  input wire logic [11:0] dm_addr,
  input wire logic        dm_rd_strobe,
  input wire logic        dm_wr_strobe,
  input wire logic [15:0] instruction_holding_register,
  input wire logic        slot_live
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  wire [3:0] ph = {phase_one, phase_two, phase_three, phase_four};

  property p_onehot;
    $onehot(ph);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("phase clocks not one-hot");
  property p_rotate;
    clk_en |=> {phase_two, phase_three, phase_four, phase_one} == $past(ph);
  endproperty
  a_rotate: assert property (p_rotate)
    else $error("phase order broken");
  property p_freeze;
    !clk_en |=> $stable(ph) && $stable(program_counter);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable low");
  property p_pc_q1;
    clk_en && phase_one |=> program_counter == $past(program_counter) + 21'h2 && pm_addr == $past(program_counter);
  endproperty
  a_pc_q1: assert property (p_pc_q1)
    else $error("counter did not step by two at phase one");
  property p_pc_mid;
    clk_en && (phase_two || phase_three) |=> $stable(program_counter);
  endproperty
  a_pc_mid: assert property (p_pc_mid)
    else $error("counter changed in phase two or three");
  property p_pc_even;
    program_counter[0] == 1'b0;
  endproperty
  a_pc_even: assert property (p_pc_even)
    else $error("counter bit zero set");
  property p_rd;
    dm_rd_strobe |-> phase_two && slot_live;
  endproperty
  a_rd: assert property (p_rd)
    else $error("data read outside live phase two");
  property p_wr;
    dm_wr_strobe |-> phase_four && slot_live;
  endproperty
  a_wr: assert property (p_wr)
    else $error("data write outside live phase four");
  property p_ir;
    !(clk_en && phase_one) |=> $stable(instruction_holding_register);
  endproperty
  a_ir: assert property (p_ir)
    else $error("instruction register changed mid cycle");
  property p_pmw;
    pm_wr_strobe |-> phase_three && slot_live;
  endproperty
  a_pmw: assert property (p_pmw)
    else $error("table write outside live phase three");
  property p_flush;
    (clk_en && phase_four) ##1 $changed(program_counter) |-> ##[1:40] (phase_two && !slot_live);
  endproperty
  a_flush: assert property (p_flush)
    else $error("prefetched word not discarded after jump");

  c_read: cover property (clk_en && dm_rd_strobe);
  c_twr: cover property (clk_en && pm_wr_strobe);
  c_ret: cover property (dm_wr_strobe && dm_addr == 12'h016);
endmodule : fep_core_monitor

bind fep_core fep_core_monitor u_mon (
  .sys_clk, .rst, .clk_en, .phase_one, .phase_two, .phase_three, .phase_four,
  .program_counter, .pm_addr, .pm_wr_strobe, .dm_addr, .dm_rd_strobe,
  .dm_wr_strobe, .instruction_holding_register, .slot_live
);

/* fep_pm_model.sv */
// Program memory model: 64 words, combinational read, byte writes.
// Assumes the bench loads mem before reset is released.
`timescale 1ns/100ps
module fep_pm_model (
  input  wire logic        sys_clk,
  input  wire logic        clk_en,
  input  wire logic [20:0] pm_addr,
  input  wire logic        pm_wr_strobe,
  input  wire logic [7:0]  pm_wr_data,
  output wire logic [15:0] pm_rdata
);
  logic [15:0] mem [0:63];
  wire         in_rng = (pm_addr[20:7] == 14'h0000);

  // Outside the array the lines carry a changing pattern
  assign pm_rdata = in_rng ? mem[pm_addr[6:1]] : ~pm_addr[15:0];

  always @(posedge sys_clk) begin
    if (clk_en && pm_wr_strobe && in_rng) begin
      if (pm_addr[0]) begin
        mem[pm_addr[6:1]][15:8] <= pm_wr_data;
      end else begin
        mem[pm_addr[6:1]][7:0] <= pm_wr_data;
      end
    end
  end
endmodule : fep_pm_model

/* fep_core_tb.sv */
// Bench of fep_core: runs a small program and checks every data write.
// Assumes fep_pm_model as program memory; data memory answers from dmv.
`timescale 1ns/100ps
module fep_core_tb;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;
  logic [7:0]  dm_rdata = 8'h00;
  logic [31:0] seed = 32'd5;
  wire  [15:0] pm_rdata;
  wire  [20:0] pm_addr;
  wire         pm_wr_strobe;
  wire  [7:0]  pm_wr_data;
  wire  [11:0] dm_addr;
  wire         dm_wr_strobe;
  wire  [7:0]  dm_wdata;
  wire  [7:0]  working_register;
  wire  [20:0] table_pointer;
  wire  [7:0]  table_latch;
  wire  [11:0] load_pointer;
  int          n_fail = 0;
  int          n_tests = 0;
  logic [19:0] exp_q[$];
  logic [7:0]  r1, r2, r3, r4;
  logic [15:0] prog [0:43] = '{
    16'h0e00, 16'h6e10, 16'hef05, 16'hf000, 16'h6e11, 16'h0e00, 16'hd001, 16'h6e12,
    16'h6e13, 16'h0e00, 16'h6620, 16'hc021, 16'hf030, 16'hc022, 16'hf031, 16'h0e01,
    16'h6ef6, 16'h0e00, 16'h6ef7, 16'h6ef8, 16'h0009, 16'h0008, 16'hcff5, 16'hf017,
    16'h0e3c, 16'h6ef5, 16'h000c, 16'h0e04, 16'hec21, 16'hf000, 16'h6e16, 16'hef25,
    16'hf000, 16'h26f9, 16'h6e14, 16'h6e15, 16'h0c00, 16'hee05, 16'hf0a7, 16'h2411,
    16'h6611, 16'h6e18, 16'hef2a, 16'hf000};

  always #12.5 sys_clk = ~sys_clk;

  fep_core dut (
    .sys_clk, .rst, .clk_en, .pm_rdata, .dm_rdata,
    .phase_one(), .phase_two(), .phase_three(), .phase_four(), .program_counter(),
    .pm_addr, .pm_wr_strobe, .pm_wr_data, .dm_addr, .dm_rd_strobe(), .dm_wr_strobe,
    .dm_wdata, .working_register, .instruction_holding_register(), .slot_live(),
    .table_pointer, .table_latch, .load_pointer
  );

  fep_pm_model pm (.sys_clk, .clk_en, .pm_addr, .pm_wr_strobe, .pm_wr_data, .pm_rdata);

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic [7:0] dmv(input logic [11:0] a);
    return (a == 12'h020) ? 8'h00 : (a[7:0] ^ 8'h5a);
  endfunction : dmv

  task automatic cmp_wr(input logic [19:0] e, input logic [19:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] dm write exp %h got %h", e, g);
    end
  endtask : cmp_wr

  task automatic cmp_val(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", what, e, g);
    end
  endtask : cmp_val

  task automatic end_sim();
    if (n_fail == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  // Data memory answer and random stalls through clock enable
  always @(negedge sys_clk) begin
    dm_rdata <= dmv(dm_addr);
    seed     <= xs(seed);
    clk_en   <= (seed[1:0] != 2'b00);
  end

  // Each write seen at the end of phase four takes the oldest note
  always @(posedge sys_clk) begin
    logic [19:0] e;
    if (!rst && clk_en && dm_wr_strobe) begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : 20'hxxxxx;
      cmp_wr(e, {dm_addr, dm_wdata});
    end
  end

  initial begin
    repeat (4000) @(posedge sys_clk);
    n_fail++;
    end_sim();
  end

  initial begin
    logic [31:0] t;
    t = xs(32'd5);
    r1 = t[7:0];
    t = xs(t);
    r2 = t[7:0];
    t = xs(t);
    r3 = t[7:0];
    prog[0][7:0] = r1;
    prog[5][7:0] = r2;
    prog[36][7:0] = r3;
    r4 = r3 + 8'h4b;
    for (int i = 0; i < 64; i++) begin
      pm.mem[i] = (i < 44) ? prog[i] : 16'h0000;
    end
    exp_q.push_back({12'h010, r1});
    exp_q.push_back({12'h013, r2});
    exp_q.push_back({12'h031, 8'h78});
    exp_q.push_back({12'h017, 8'h10});
    exp_q.push_back({12'h016, r3});
    exp_q.push_back({12'h018, r4});
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    rst <= 1'b0;
    for (int k = 0; k < 2000 && exp_q.size() != 0; k++) begin
      @(posedge sys_clk);
    end
    cmp_val("queue left", 32'h0, exp_q.size());
    repeat (40) @(negedge sys_clk);
    cmp_val("working", {24'h0, r4}, {24'h0, working_register});
    cmp_val("lptr", 32'h5a7, {20'h0, load_pointer});
    cmp_val("tptr", 32'h2, {11'h0, table_pointer});
    cmp_val("tlatch", 32'h3c, {24'h0, table_latch});
    cmp_val("pword", 32'h6e3c, {16'h0, pm.mem[1]});
    end_sim();
  end
endmodule : fep_core_tb
